//--- rtl/maf_defs.svh
`ifndef MAF_DEFS_SVH
`define MAF_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MAF_OFS_HASH_LO 8'h00
`define MAF_OFS_HASH_HI 8'h04
`define MAF_OFS_SLOT_BASE 8'h08
`define MAF_OFS_TYPE 8'h28
`define MAF_OFS_PHY_CTRL 8'h2c
`define MAF_OFS_PAUSE_CNT 8'h30

// ----------------------------------------
// Field positions and reset value
// ----------------------------------------
`define MAF_PHY_RMII_BIT 0
`define MAF_PHY_CLKGATE_BIT 1
`define MAF_REG_RESET 32'h0000_0000

// ----------------------------------------
// Good pause frame length limits in bytes
// ----------------------------------------
`define MAF_LEN_MIN 11'h040
`define MAF_LEN_MAX 11'h5ee
`define MAF_LEN_MAX_BIG 11'h600

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define MAF_RESP_OKAY 2'h0
`define MAF_RESP_SLVERR 2'h2

`endif

//--- rtl/maf_pkg.sv
`default_nettype none

package maf_pkg;

  // Received pause frame report from the receive path
  typedef struct packed {
    logic done;
    logic [10:0] length;
    logic fcs_err;
    logic align_err;
    logic symbol_err;
  } maf_pause_t;

  // Received frame header for address and type compare
  typedef struct packed {
    logic valid;
    logic [47:0] dest;
    logic [15:0] ftype;
  } maf_rx_hdr_t;

  // Bus channel states
  typedef enum logic {WR_COLLECT, WR_RESP} maf_wr_state_t;
  typedef enum logic {RD_IDLE, RD_RESP} maf_rd_state_t;

endpackage

`default_nettype wire

//--- rtl/maf_regs.sv
// How it works
// - Hash filter bits 31..0 live in the hash-low register.
// - Hash filter bits 63..32 live in the hash-high register.
// - Four address slots exist, each a read/write low and high register.
// - A slot low register holds the lower 32 destination address bits.
// - Bit 0 of a slot low register is the multicast bit of the first byte.
// - A 16-bit type value is compared with each frame's type/length.
// - The interface-select bit picks RMII when one and MII when zero.
// - The clock gate bit passes the transceiver clock or stops it.
// - Statistics counters clear on read and stick at all ones.
// - Receive counters advance only while receive is enabled.
// - Counter writes count only while the stats write enable is set.
// - The 16-bit pause counter adds one per good pause frame.
// - A good pause frame is 64..1518 (1536 big) bytes with no errors.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "maf_defs.svh"

module maf_regs
  import maf_pkg::*;
#(
  parameter int SLOT_COUNT = 4,
  parameter int PAUSE_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic rx_enable_in,
  input wire logic stats_write_en_in,
  input wire logic big_frame_en_in,
  input wire maf_pause_t pause_in,
  input wire maf_rx_hdr_t rx_hdr_in,
  input wire logic xcvr_clk_in,
  output logic xcvr_clk_out,
  output logic rmii_mode_out,
  output logic [63:0] hash_filter_out,
  output logic match_valid_out,
  output logic [SLOT_COUNT-1:0] slot_hit_out,
  output logic type_hit_out
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (SLOT_COUNT < 1 || SLOT_COUNT > 4) begin : g_bad_slots
    $error("SLOT_COUNT must be 1 to 4");
  end
  if (PAUSE_W < 1 || PAUSE_W > 32) begin : g_bad_width
    $error("PAUSE_W must be 1 to 32");
  end

  localparam logic [2:0] SLOT_N = 3'(SLOT_COUNT);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] hash_lo_reg;
  logic [31:0] hash_hi_reg;
  logic [31:0] slot_lo_reg [SLOT_COUNT];
  logic [15:0] slot_hi_reg [SLOT_COUNT];
  logic [15:0] type_reg;
  logic [1:0] phy_ctrl_reg;
  logic [PAUSE_W-1:0] pause_cnt_reg;
  logic [PAUSE_W-1:0] pause_cnt_next;

  // Write channel holding
  maf_wr_state_t wr_state_reg;
  logic aw_held_reg;
  logic [7:0] waddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;

  // Read channel
  maf_rd_state_t rd_state_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Match results
  logic match_valid_reg;
  logic [SLOT_COUNT-1:0] slot_hit_reg;
  logic type_hit_reg;

  logic do_write;
  logic ar_take;
  logic [1:0] wr_slot;
  logic wr_slot_ok;
  logic [1:0] rd_slot;
  logic rd_slot_ok;
  logic wr_known;
  logic [31:0] rd_data;
  logic rd_ok;
  logic pause_good;
  logic pause_inc;
  logic cnt_wr;
  logic rd_clr;
  logic cnt_sat;
  logic [SLOT_COUNT-1:0] slot_eq;

  // Byte lanes of a write merged over the old value
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Slots sit in pairs of words from the slot base upward
  assign wr_slot = 2'(waddr_reg[5:3] - 3'h1);
  assign wr_slot_ok = waddr_reg >= `MAF_OFS_SLOT_BASE &&
                      waddr_reg < `MAF_OFS_TYPE &&
                      {1'b0, wr_slot} < SLOT_N;
  assign rd_slot = 2'(s_axi_araddr_in[5:3] - 3'h1);
  assign rd_slot_ok = s_axi_araddr_in >= `MAF_OFS_SLOT_BASE &&
                      s_axi_araddr_in < `MAF_OFS_TYPE &&
                      {1'b0, rd_slot} < SLOT_N;

  // Known write addresses
  always_comb begin
    case (waddr_reg)
      `MAF_OFS_HASH_LO, `MAF_OFS_HASH_HI, `MAF_OFS_TYPE,
      `MAF_OFS_PHY_CTRL, `MAF_OFS_PAUSE_CNT: begin
        wr_known = 1'b1;
      end
      default: begin
        wr_known = wr_slot_ok;
      end
    endcase
  end

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data are taken in either order
  assign s_axi_awready_out = wr_state_reg == WR_COLLECT && !aw_held_reg;
  assign s_axi_wready_out = wr_state_reg == WR_COLLECT && !w_held_reg;
  assign do_write = wr_state_reg == WR_COLLECT && aw_held_reg &&
                    w_held_reg;
  assign s_axi_bvalid_out = wr_state_reg == WR_RESP;
  assign s_axi_bresp_out = bresp_reg;

  // Address holding
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      aw_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_reg <= 1'b1;
      waddr_reg <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Data holding
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      w_held_reg <= 1'b0;
      wdata_reg <= `MAF_REG_RESET;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata_in;
      wstrb_reg <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Response state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_state_reg <= WR_COLLECT;
      bresp_reg <= `MAF_RESP_OKAY;
    end else begin
      case (wr_state_reg)
        WR_COLLECT: begin
          if (do_write) begin
            wr_state_reg <= WR_RESP;
            bresp_reg <= wr_known ? `MAF_RESP_OKAY : `MAF_RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready_in) begin
            wr_state_reg <= WR_COLLECT;
          end
        end
        default: begin
          wr_state_reg <= WR_COLLECT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Filter registers
  // ----------------------------------------
  // Hash filter halves
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      hash_lo_reg <= `MAF_REG_RESET;
      hash_hi_reg <= `MAF_REG_RESET;
    end else if (do_write) begin
      if (waddr_reg == `MAF_OFS_HASH_LO) begin
        hash_lo_reg <= merge_bytes(hash_lo_reg, wdata_reg,
                                   wstrb_reg);
      end
      if (waddr_reg == `MAF_OFS_HASH_HI) begin
        hash_hi_reg <= merge_bytes(hash_hi_reg, wdata_reg,
                                   wstrb_reg);
      end
    end
  end

  // Specific address slots, high word keeps only 16 bits
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot_lo_reg[i] <= `MAF_REG_RESET;
        slot_hi_reg[i] <= 16'h0000;
      end
    end else if (do_write && wr_slot_ok) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        if (wr_slot == 2'(i) && !waddr_reg[2]) begin
          slot_lo_reg[i] <= merge_bytes(slot_lo_reg[i], wdata_reg,
                                        wstrb_reg);
        end
        if (wr_slot == 2'(i) && waddr_reg[2]) begin
          slot_hi_reg[i] <= 16'(merge_bytes({16'h0000, slot_hi_reg[i]},
                                wdata_reg, wstrb_reg));
        end
      end
    end
  end

  // Type compare value and PHY interface control
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      type_reg <= 16'h0000;
      phy_ctrl_reg <= 2'h0;
    end else if (do_write) begin
      if (waddr_reg == `MAF_OFS_TYPE) begin
        type_reg <= 16'(merge_bytes({16'h0000, type_reg},
                        wdata_reg, wstrb_reg));
      end
      if (waddr_reg == `MAF_OFS_PHY_CTRL && wstrb_reg[0]) begin
        phy_ctrl_reg <= wdata_reg[1:0];
      end
    end
  end

  assign hash_filter_out = {hash_hi_reg, hash_lo_reg};
  assign rmii_mode_out = phy_ctrl_reg[`MAF_PHY_RMII_BIT];

  // Clock gate; change the enable only while the PHY is idle
  assign xcvr_clk_out = xcvr_clk_in &
                        phy_ctrl_reg[`MAF_PHY_CLKGATE_BIT];

  // ----------------------------------------
  // Frame compare
  // ----------------------------------------
  // Full 48-bit compare; bit 0 is the first byte's multicast bit
  for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
    assign slot_eq[g] = rx_hdr_in.dest ==
                        {slot_hi_reg[g], slot_lo_reg[g]};
  end

  // Registered match results, one pulse per header
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      match_valid_reg <= 1'b0;
      slot_hit_reg <= '0;
      type_hit_reg <= 1'b0;
    end else begin
      match_valid_reg <= rx_hdr_in.valid;
      if (rx_hdr_in.valid) begin
        slot_hit_reg <= slot_eq;
        type_hit_reg <= rx_hdr_in.ftype == type_reg;
      end
    end
  end

  assign match_valid_out = match_valid_reg;
  assign slot_hit_out = slot_hit_reg;
  assign type_hit_out = type_hit_reg;

  // ----------------------------------------
  // Pause frame counter
  // ----------------------------------------
  // Good frame check
  assign pause_good = !pause_in.fcs_err && !pause_in.align_err &&
                      !pause_in.symbol_err &&
                      pause_in.length >= `MAF_LEN_MIN &&
                      pause_in.length <= (big_frame_en_in ?
                      `MAF_LEN_MAX_BIG : `MAF_LEN_MAX);
  assign pause_inc = pause_in.done && pause_good &&
                     rx_enable_in;
  assign cnt_wr = do_write && waddr_reg == `MAF_OFS_PAUSE_CNT &&
                  stats_write_en_in;
  assign rd_clr = ar_take && s_axi_araddr_in == `MAF_OFS_PAUSE_CNT;
  assign cnt_sat = &pause_cnt_reg;

  // Next count; a frame in the clearing cycle is kept
  always_comb begin
    pause_cnt_next = pause_cnt_reg;
    if (cnt_wr) begin
      pause_cnt_next = PAUSE_W'(merge_bytes(32'(pause_cnt_reg),
                       wdata_reg, wstrb_reg));
    end else if (rd_clr) begin
      pause_cnt_next = pause_inc ? PAUSE_W'(1) : '0;
    end else if (pause_inc && !cnt_sat) begin
      pause_cnt_next = pause_cnt_reg + PAUSE_W'(1);
    end
  end

  // Counter state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pause_cnt_reg <= '0;
    end else begin
      pause_cnt_reg <= pause_cnt_next;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready_out = rd_state_reg == RD_IDLE;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign s_axi_rvalid_out = rd_state_reg == RD_RESP;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  // Read data select
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (rd_slot_ok) begin
      if (s_axi_araddr_in[2]) begin
        rd_data = {16'h0000, slot_hi_reg[rd_slot]};
      end else begin
        rd_data = slot_lo_reg[rd_slot];
      end
    end else begin
      case (s_axi_araddr_in)
        `MAF_OFS_HASH_LO: rd_data = hash_lo_reg;
        `MAF_OFS_HASH_HI: rd_data = hash_hi_reg;
        `MAF_OFS_TYPE: rd_data = {16'h0000, type_reg};
        `MAF_OFS_PHY_CTRL: rd_data = {30'h0, phy_ctrl_reg};
        `MAF_OFS_PAUSE_CNT: rd_data = 32'(pause_cnt_reg);
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Read response state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg <= `MAF_REG_RESET;
      rresp_reg <= `MAF_RESP_OKAY;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state_reg <= RD_RESP;
            rdata_reg <= rd_data;
            rresp_reg <= rd_ok ? `MAF_RESP_OKAY : `MAF_RESP_SLVERR;
          end
        end
        RD_RESP: begin
          if (s_axi_rready_in) begin
            rd_state_reg <= RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  hash_low_a: assert property (
    do_write && waddr_reg == `MAF_OFS_HASH_LO && wstrb_reg == 4'hf
    |=> hash_filter_out[31:0] == $past(wdata_reg))
    else $error("hash low not written");

  hash_high_a: assert property (
    do_write && waddr_reg == `MAF_OFS_HASH_HI && wstrb_reg == 4'hf
    |=> hash_filter_out[63:32] == $past(wdata_reg))
    else $error("hash high not written");

  slot_match_a: assert property (
    rx_hdr_in.valid && rx_hdr_in.dest == {slot_hi_reg[0], slot_lo_reg[0]}
    |=> match_valid_out && slot_hit_out[0])
    else $error("slot match missed");

  mcast_bit_a: assert property (
    rx_hdr_in.valid && rx_hdr_in.dest[0] != slot_lo_reg[0][0]
    |=> !slot_hit_out[0])
    else $error("multicast bit ignored");

  slot_high_a: assert property (
    ar_take && rd_slot_ok && s_axi_araddr_in[2]
    |=> s_axi_rvalid_out && s_axi_rdata_out[31:16] == 16'h0000)
    else $error("slot high upper bits not zero");

  type_hit_a: assert property (
    rx_hdr_in.valid ##1 match_valid_out
    |-> type_hit_out == ($past(rx_hdr_in.ftype) == $past(type_reg)))
    else $error("type compare wrong");

  rmii_sel_a: assert property (
    do_write && waddr_reg == `MAF_OFS_PHY_CTRL && wstrb_reg[0]
    |=> rmii_mode_out == $past(wdata_reg[0]))
    else $error("interface select not applied");

  clk_gate_a: assert property (
    !phy_ctrl_reg[`MAF_PHY_CLKGATE_BIT] |-> !xcvr_clk_out)
    else $error("gated clock leaks");

  read_clear_a: assert property (
    rd_clr && !cnt_wr |=> pause_cnt_reg == PAUSE_W'($past(pause_inc)))
    else $error("counter not cleared on read");

  cnt_stick_a: assert property (
    cnt_sat && !rd_clr && !cnt_wr |=> cnt_sat)
    else $error("counter wrapped");

  rx_gate_a: assert property (
    !rx_enable_in && !rd_clr && !cnt_wr |=> $stable(pause_cnt_reg))
    else $error("count while receive disabled");

  wr_lock_a: assert property (
    !stats_write_en_in && !rd_clr && !pause_inc
    |=> $stable(pause_cnt_reg))
    else $error("locked counter changed");

  cnt_step_a: assert property (
    pause_inc && !cnt_sat && !rd_clr && !cnt_wr
    |=> pause_cnt_reg == $past(pause_cnt_reg) + PAUSE_W'(1))
    else $error("counter did not step");

  good_len_a: assert property (
    pause_in.done && (pause_in.length < `MAF_LEN_MIN ||
    pause_in.length > `MAF_LEN_MAX_BIG) |-> !pause_inc)
    else $error("bad length counted");

endmodule

`default_nettype wire

//--- verification/mac_addr_filter_stats_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end

module mac_addr_filter_stats_regs_bench
  import maf_pkg::*;
;
  logic clk_in = 1'b0, rst_b_in = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic rx_en = 1'b0, st_wr_en = 1'b0, big_en = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire maf_pause_t pause;
  wire maf_rx_hdr_t hdr;
  wire logic xclk, xclk_out, rmii, mvalid, thit;
  wire logic [63:0] hash;
  wire logic [3:0] shit;
  int err_count = 0, cmp_count = 0, cnt;
  logic [1:0] resp;
  logic [31:0] rd_val;

  always #25 clk_in = ~clk_in;

  maf_regs i_maf_regs (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .rx_enable_in(rx_en),
    .stats_write_en_in(st_wr_en), .big_frame_en_in(big_en),
    .pause_in(pause), .rx_hdr_in(hdr), .xcvr_clk_in(xclk),
    .xcvr_clk_out(xclk_out), .rmii_mode_out(rmii),
    .hash_filter_out(hash), .match_valid_out(mvalid),
    .slot_hit_out(shit), .type_hit_out(thit));

  maf_phy_model i_maf_phy_model (.clk_in(clk_in), .pause_out(pause),
    .hdr_out(hdr), .xcvr_clk_out(xclk));

  // ----------------------------------------
  // Register bus master tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_t, w_t;
    // Waits have no limit of their own; the watchdog ends a hang
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_in);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      @(posedge clk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (awvalid && !aw_t || wvalid && !w_t);
    do begin
      @(negedge clk_in);
    end while (!bvalid);
    r = bresp;
    @(posedge clk_in);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_in);
    end while (!arready);
    @(posedge clk_in);
    arvalid <= 1'b0;
    do begin
      @(negedge clk_in);
    end while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk_in);
    rready <= 1'b0;
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Register rows and pause frame rows
  // ----------------------------------------
  logic [7:0] ta[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [31:0] td[12] = '{32'h89ab_cdef, 32'h0123_4567, 32'h4433_2210,
    32'hdead_6655, 32'h4433_2211, 32'hbeef_6656, 32'h4433_2212,
    32'hf00d_6657, 32'h4433_2213, 32'hcafe_6658, 32'h5a5a_0888,
    32'hffff_fffe};
  logic [31:0] te[12] = '{32'h89ab_cdef, 32'h0123_4567, 32'h4433_2210,
    32'h0000_6655, 32'h4433_2211, 32'h0000_6656, 32'h4433_2212,
    32'h0000_6657, 32'h4433_2213, 32'h0000_6658, 32'h0000_0888,
    32'h0000_0002};
  logic [10:0] pl[9] = '{11'd64, 11'd1518, 11'd63, 11'd1519, 11'd64,
    11'd64, 11'd64, 11'd1536, 11'd1537};
  logic [2:0] pe[9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1, 3'h0,
    3'h0};

  // Watchdog
  initial begin
    #200us;
    err_count++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Reset values, then write and read back every register but the pause counter
    foreach (ta[i]) begin
      rd(ta[i], rd_val, resp);
      `CHK({resp, rd_val}, 34'h0)
    end
    `CHK(rmii, 1'b0)
    foreach (ta[i]) begin
      wr(ta[i], td[i], resp);
      `CHK(resp, 2'h0)
      rd(ta[i], rd_val, resp);
      `CHK({resp, rd_val}, {2'h0, te[i]})
    end
    `CHK(hash, 64'h0123_4567_89ab_cdef)
    `CHK(rmii, 1'b0)
    @(posedge xclk); #1 `CHK(xclk_out, 1'b1)
    @(negedge xclk); #1 `CHK(xclk_out, 1'b0)
    wr(8'h2c, 32'h0000_0001, resp);
    #1 `CHK(rmii, 1'b1)
    @(posedge xclk); #1 `CHK(xclk_out, 1'b0)
    // Unmapped place answers with an error and no data
    wr(8'h34, 32'h1234_5678, resp);
    `CHK(resp, 2'h2)
    rd(8'h34, rd_val, resp);
    `CHK({resp, rd_val}, {2'h2, 32'h0})
    // Header compare: slot 2 match, then first byte lsb flipped
    i_maf_phy_model.send_hdr(8'h12, 8'h22, 8'h33, 8'h44, 8'h57, 8'h66,
                             16'h0888);
    #1 `CHK({mvalid, shit, thit}, {1'b1, 4'b0100, 1'b1})
    i_maf_phy_model.send_hdr(8'h13, 8'h22, 8'h33, 8'h44, 8'h57, 8'h66,
                             16'h0889);
    #1 `CHK({mvalid, shit, thit}, {1'b1, 4'b0000, 1'b0})
    // Pause frames of every length edge and error kind
    rx_en <= 1'b1;
    cnt = 0;
    foreach (pl[i]) begin
      big_en <= (i >= 7);
      i_maf_phy_model.send_pause(pl[i], pe[i]);
      if (pl[i] >= 64 && pl[i] <= ((i >= 7) ? 1536 : 1518) && pe[i] == 0)
        cnt++;
    end
    @(posedge clk_in);
    rd(8'h30, rd_val, resp);
    `CHK(rd_val, cnt)
    rd(8'h30, rd_val, resp);
    `CHK(rd_val, 32'h0)
    // No counting with receive off
    rx_en <= 1'b0;
    i_maf_phy_model.send_pause(11'd100, 3'h0);
    rx_en <= 1'b1;
    rd(8'h30, rd_val, resp);
    `CHK(rd_val, 32'h0)
    // Counter writes obey the write enable; full counter sticks
    wr(8'h30, 32'h0000_0005, resp);
    rd(8'h30, rd_val, resp);
    `CHK(rd_val, 32'h0)
    st_wr_en <= 1'b1;
    wr(8'h30, 32'hffff_ffff, resp);
    st_wr_en <= 1'b0;
    i_maf_phy_model.send_pause(11'd64, 3'h0);
    @(posedge clk_in);
    rd(8'h30, rd_val, resp);
    `CHK(rd_val, 32'h0000_ffff)
    // Second reset clears registers
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(8'h00, rd_val, resp);
    `CHK({rd_val, hash[63:32], rmii}, {64'h0, 1'b0})
    close_out();
  end
endmodule

`default_nettype wire

//--- verification/maf_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

module maf_phy_model
  import maf_pkg::*;
(
  input wire logic clk_in,
  output maf_pause_t pause_out,
  output maf_rx_hdr_t hdr_out,
  output logic xcvr_clk_out
);
  // ----------------------------------------
  // Free-running transceiver clock, 25 MHz
  // ----------------------------------------
  initial begin
    pause_out = '0;
    hdr_out = '0;
    xcvr_clk_out = 1'b0;
  end
  always #20 xcvr_clk_out = ~xcvr_clk_out;

  // One pause report; fields turn to junk once done drops
  task automatic send_pause(input logic [10:0] len, input logic [2:0] errs);
    @(posedge clk_in);
    pause_out <= {1'b1, len, errs};
    @(posedge clk_in);
    pause_out <= {1'b0, ~len, ~errs};
  endtask

  // Header from wire-order bytes; first byte lands in bits 7:0
  task automatic send_hdr(input logic [7:0] b0, b1, b2, b3, b4, b5,
                          input logic [15:0] ftype);
    @(posedge clk_in);
    hdr_out <= {1'b1, b5, b4, b3, b2, b1, b0, ftype};
    @(posedge clk_in);
    hdr_out <= {1'b0, ~b5, ~b4, ~b3, ~b2, ~b1, ~b0, ~ftype};
  endtask
endmodule

`default_nettype wire
